// *** include/supply_cmd_pkg.sv ***
// package: command codes, limits, register bit positions and timing for the set-point core
package supply_cmd_pkg;

    localparam int CLK_HZ          = 100_000_000;
    localparam int DWELL_UNIT_MS   = 10;
    localparam int DWELL_UNIT_CYC  = CLK_HZ / 1000 * DWELL_UNIT_MS;

    localparam int VAL_W           = 16;
    localparam int PER_W           = 14;
    localparam int STEP_W          = 7;
    localparam int ERRQ_DEPTH      = 8;
    localparam int ERRQ_PTR_W      = 3;

    localparam logic [STEP_W-1:0] STEP_LAST   = 7'h63;
    localparam logic [STEP_W-1:0] STEP_FIRST  = 7'h00;
    localparam logic [PER_W-1:0]  PER_STOP    = 14'h0000;
    localparam logic [PER_W-1:0]  PER_WRAP    = 14'h270E;
    localparam logic [PER_W-1:0]  PER_HOLD    = 14'h270F;
    localparam logic [PER_W-1:0]  PER_MIN     = 14'h0000;
    localparam logic [PER_W-1:0]  PER_MAX     = 14'h270F;

    localparam logic [VAL_W-1:0]  LEVEL_MIN   = 16'h0000;
    localparam logic [VAL_W-1:0]  LEVEL_MAX   = 16'hFFFF;

    localparam logic [15:0] ERR_NONE      = 16'h0000;
    localparam logic [15:0] ERR_OVERFLOW  = 16'hFEA2;
    localparam logic [15:0] ERR_RANGE     = 16'hFF92;

    localparam int OPB_ARM = 0;
    localparam int OPB_SS  = 1;
    localparam int OPB_LCK = 2;
    localparam int OPB_INT = 3;
    localparam int OPB_EXT = 4;
    localparam int OPB_WTG = 5;
    localparam int OPB_SBY = 6;
    localparam int OPB_PWR = 7;
    localparam int OPB_CV  = 8;
    localparam int OPB_RS  = 9;
    localparam int OPB_CC  = 10;
    localparam int OPB_SOA = 11;
    localparam int QB_OV   = 0;
    localparam int QB_OC   = 1;

    typedef enum logic [4:0] {
        CMD_VOLT      = 5'h00, CMD_VOLT_TRIG = 5'h01, CMD_VOLT_PROT = 5'h02,
        CMD_CURR      = 5'h03, CMD_CURR_TRIG = 5'h04, CMD_CURR_PROT = 5'h05,
        CMD_PER       = 5'h06, CMD_MEM_SEL   = 5'h07, CMD_ARM       = 5'h08,
        CMD_START     = 5'h09, CMD_STOP      = 5'h0A, CMD_PROT_CLR  = 5'h0B,
        CMD_INIT      = 5'h0C, CMD_INIT_CONT = 5'h0D, CMD_TRIG      = 5'h0E,
        CMD_ABORT     = 5'h0F,
        Q_VOLT        = 5'h10, Q_VOLT_TRIG   = 5'h11, Q_VOLT_PROT   = 5'h12,
        Q_CURR        = 5'h13, Q_CURR_TRIG   = 5'h14, Q_CURR_PROT   = 5'h15,
        Q_PER         = 5'h16, Q_MEAS_VOLT   = 5'h17, Q_MEAS_CURR   = 5'h18,
        Q_VERSION     = 5'h19, Q_ERROR       = 5'h1A, Q_OPER        = 5'h1B,
        Q_QUES        = 5'h1C
    } cmd_code_t;

    typedef enum logic [1:0] {
        QUAL_NONE = 2'h0, QUAL_MIN = 2'h1, QUAL_MAX = 2'h2
    } qual_t;

    typedef struct packed {
        cmd_code_t        code;
        qual_t            qual;
        logic [VAL_W-1:0] value;
    } cmd_t;

    typedef struct packed {
        logic [15:0]      code;
        logic [VAL_W-1:0] value;
    } answer_t;

    typedef struct packed {
        logic [VAL_W-1:0] volt;
        logic [VAL_W-1:0] curr;
        logic [VAL_W-1:0] over_voltage_trip;
        logic [VAL_W-1:0] over_current_trip;
        logic [PER_W-1:0] step_dwell_period;
    } step_t;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001, SEQ_RUN = 3'b010, SEQ_HOLD = 3'b100
    } seq_state_t;

endpackage : supply_cmd_pkg

// *** logic/supply_setpoint_command_core.sv ***
// design: command core holding set points, trips, auto-sequencer, error queue, status
`timescale 1ns/1ps
`default_nettype none

module supply_setpoint_command_core
    import supply_cmd_pkg::*;
#(
    parameter int                DWELL_CYC = DWELL_UNIT_CYC,
    parameter logic [15:0]       FW_REV    = 16'h0100, // arbitrary
    parameter logic [15:0]       HW_REV    = 16'h0100  // arbitrary
)(
    input  wire logic             i_mclk,
    input  wire logic             i_reset,
    input  wire logic             i_cmd_valid,
    input  wire cmd_t             i_cmd,
    input  wire logic [VAL_W-1:0] i_meas_volt,
    input  wire logic [VAL_W-1:0] i_meas_curr,
    input  wire logic [7:0]       i_status_pins,
    output logic                  o_ans_valid,
    output answer_t               o_ans,
    output logic [VAL_W-1:0]      o_volt_set,
    output logic [VAL_W-1:0]      o_curr_set,
    output logic [VAL_W-1:0]      o_ovt_level,
    output logic [VAL_W-1:0]      o_oct_level,
    output logic                  o_output_on,
    output logic [15:0]           o_operation_condition,
    output logic [15:0]           o_questionable
);

    // ------------------------------------------------------------
    // input synchronisers for analog-side measurements and pins
    // ------------------------------------------------------------
    logic [VAL_W-1:0] mv_s1, mv_s2, mc_s1, mc_s2;
    logic [7:0]       st_s1, st_s2;
    // two stages each; first stage feeds only the second
    always_ff @(posedge i_mclk)
    begin
        mv_s1 <= i_meas_volt;
        mv_s2 <= mv_s1;
        mc_s1 <= i_meas_curr;
        mc_s2 <= mc_s1;
        st_s1 <= i_status_pins;
        st_s2 <= st_s1;
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic cmd_is;
    logic in_range;
    logic per_in_range;
    logic wr_ok;
    assign in_range     = (i_cmd.value >= LEVEL_MIN) && (i_cmd.value <= LEVEL_MAX);
    assign per_in_range = (i_cmd.value <= VAL_W'(PER_MAX));
    assign cmd_is       = i_cmd_valid;
    assign wr_ok        = (i_cmd.code == CMD_PER) ? per_in_range : in_range;

    // ------------------------------------------------------------
    // trigger subsystem state
    // ------------------------------------------------------------
    logic initiated, init_cont, armed, volt_pend, curr_pend;
    logic trig_fire;
    assign trig_fire = cmd_is && i_cmd.code == CMD_TRIG && initiated;

    // triggers ignored unless initiated; single shot unless continuous
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            initiated <= 1'b0;
            init_cont <= 1'b0;
        end
        else if (cmd_is)
        begin
            unique case (i_cmd.code)
                CMD_INIT:      initiated <= 1'b1;
                CMD_INIT_CONT:
                begin
                    init_cont <= i_cmd.value[0];
                    if (i_cmd.value[0])
                        initiated <= 1'b1;
                end
                CMD_TRIG:      if (initiated) initiated <= init_cont;
                CMD_ABORT:     initiated <= init_cont;
                default:       ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // set points, pending levels and trip levels
    // ------------------------------------------------------------
    logic [VAL_W-1:0] volt_imm, volt_trg, curr_imm, curr_trg, over_voltage_trip, over_current_trip;
    logic             seq_load;
    step_t            step_now;

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            volt_imm  <= LEVEL_MIN;
            volt_trg  <= LEVEL_MIN;
            curr_imm  <= LEVEL_MIN;
            curr_trg  <= LEVEL_MIN;
            over_voltage_trip       <= LEVEL_MAX;
            over_current_trip       <= LEVEL_MAX;
            volt_pend <= 1'b0;
            curr_pend <= 1'b0;
        end
        else if (seq_load)
        begin
            // a sequencer step rewrites all four parameters
            volt_imm <= step_now.volt;
            curr_imm <= step_now.curr;
            over_voltage_trip      <= step_now.over_voltage_trip;
            over_current_trip      <= step_now.over_current_trip;
        end
        else if (trig_fire)
        begin
            if (volt_pend) volt_imm <= volt_trg;
            if (curr_pend) curr_imm <= curr_trg;
            volt_pend <= 1'b0;
            curr_pend <= 1'b0;
        end
        else if (cmd_is && wr_ok)
        begin
            unique case (i_cmd.code)
                CMD_VOLT:      volt_imm <= i_cmd.value;
                CMD_CURR:      curr_imm <= i_cmd.value;
                CMD_VOLT_TRIG:
                begin
                    volt_trg  <= i_cmd.value;
                    volt_pend <= 1'b1;
                end
                CMD_CURR_TRIG:
                begin
                    curr_trg  <= i_cmd.value;
                    curr_pend <= 1'b1;
                end
                CMD_VOLT_PROT: over_voltage_trip <= i_cmd.value;
                CMD_CURR_PROT: over_current_trip <= i_cmd.value;
                CMD_ABORT:
                begin
                    volt_pend <= 1'b0;
                    curr_pend <= 1'b0;
                end
                default:       ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // protection latches; trip set wins over a same-cycle clear
    // ------------------------------------------------------------
    logic ov_trip, oc_trip, ov_now, oc_now, prot_clr;
    assign ov_now   = mv_s2 > over_voltage_trip;
    assign oc_now   = mc_s2 > over_current_trip;
    assign prot_clr = cmd_is && i_cmd.code == CMD_PROT_CLR;

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            ov_trip <= 1'b0;
            oc_trip <= 1'b0;
        end
        else
        begin
            // clear takes effect only once the cause is gone
            ov_trip <= ov_now || (ov_trip && !prot_clr);
            oc_trip <= oc_now || (oc_trip && !prot_clr);
        end
    end

    // ------------------------------------------------------------
    // auto-sequencer: memory of steps and dwell timer
    // ------------------------------------------------------------
    step_t             mem [0:STEP_LAST];
    logic [STEP_W-1:0] sel;
    seq_state_t        seq;
    logic [31:0]       tick;
    logic [PER_W-1:0]  units;
    logic              start_cmd, stop_cmd, fault;
    logic [STEP_W-1:0] next_sel;

    assign step_now  = mem[sel];
    assign start_cmd = cmd_is && i_cmd.code == CMD_START;
    assign stop_cmd  = cmd_is && i_cmd.code == CMD_STOP;
    assign fault     = ov_trip || oc_trip;
    // wrap code forces location zero; top location wraps too
    assign next_sel  = (step_now.step_dwell_period == PER_WRAP || sel == STEP_LAST)
                       ? STEP_FIRST : sel + 7'h01;

    // step memory: the selected step captures programmed writes
    always_ff @(posedge i_mclk)
    begin
        if (cmd_is && wr_ok && seq == SEQ_IDLE)
        begin
            unique case (i_cmd.code)
                CMD_VOLT:      mem[sel].volt <= i_cmd.value;
                CMD_CURR:      mem[sel].curr <= i_cmd.value;
                CMD_VOLT_PROT: mem[sel].over_voltage_trip  <= i_cmd.value;
                CMD_CURR_PROT: mem[sel].over_current_trip  <= i_cmd.value;
                CMD_PER:       mem[sel].step_dwell_period  <= i_cmd.value[PER_W-1:0];
                default:       ;
            endcase
        end
    end

    // sequencer state, output contactor and step selection
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            seq         <= SEQ_IDLE;
            sel         <= STEP_FIRST;
            armed       <= 1'b0;
            o_output_on <= 1'b0;
            tick        <= '0;
            units       <= '0;
            seq_load    <= 1'b0;
        end
        else
        begin
            seq_load <= 1'b0;
            if (cmd_is && i_cmd.code == CMD_ARM && seq == SEQ_IDLE)
                armed <= i_cmd.value[0];
            if (cmd_is && i_cmd.code == CMD_MEM_SEL && seq == SEQ_IDLE
                && i_cmd.value <= VAL_W'(STEP_LAST))
                sel <= i_cmd.value[STEP_W-1:0];
            if (fault || stop_cmd)
            begin
                seq         <= SEQ_IDLE;
                o_output_on <= 1'b0;
            end
            else
            begin
                unique case (seq)
                    SEQ_IDLE:
                        if (start_cmd)
                        begin
                            o_output_on <= 1'b1;
                            if (armed)
                            begin
                                seq      <= SEQ_RUN;
                                seq_load <= 1'b1;
                                tick     <= '0;
                                units    <= '0;
                            end
                        end
                    SEQ_RUN, SEQ_HOLD:
                    begin
                        if (step_now.step_dwell_period == PER_STOP)
                        begin
                            seq         <= SEQ_IDLE;
                            o_output_on <= 1'b0;
                        end
                        else if (step_now.step_dwell_period == PER_HOLD && !start_cmd)
                            seq <= SEQ_HOLD;
                        else if (start_cmd || units >= step_now.step_dwell_period)
                        begin
                            sel      <= next_sel;
                            seq      <= SEQ_RUN;
                            seq_load <= 1'b1;
                            tick     <= '0;
                            units    <= '0;
                        end
                        else if (tick == 32'(DWELL_CYC - 1))
                        begin
                            tick  <= '0;
                            units <= units + 14'h0001;
                        end
                        else
                            tick <= tick + 32'h0000_0001;
                    end
                    default: seq <= SEQ_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // error queue: circular buffer, overflow marks the tail entry
    // ------------------------------------------------------------
    logic [15:0]           errq [0:ERRQ_DEPTH-1];
    logic [ERRQ_PTR_W-1:0] rd_ptr, wr_ptr;
    logic [ERRQ_PTR_W:0]   cnt;
    logic                  err_push, err_pop;
    logic                  is_write;
    assign is_write = i_cmd.code inside {CMD_VOLT, CMD_VOLT_TRIG, CMD_VOLT_PROT,
                                         CMD_CURR, CMD_CURR_TRIG, CMD_CURR_PROT, CMD_PER};
    assign err_push = cmd_is && is_write && !wr_ok;
    assign err_pop  = cmd_is && i_cmd.code == Q_ERROR && cnt != '0;

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            cnt    <= '0;
        end
        else
        begin
            if (err_pop)
                rd_ptr <= rd_ptr + 3'h1;
            if (err_push && cnt < 4'(ERRQ_DEPTH))
            begin
                errq[wr_ptr] <= ERR_RANGE;
                wr_ptr       <= wr_ptr + 3'h1;
            end
            else if (err_push)
            begin
                // queue full: newest entry is replaced, so a full queue alone never reports overflow
                errq[wr_ptr - 3'h1] <= ERR_OVERFLOW;
            end
            if ((err_push && cnt < 4'(ERRQ_DEPTH)) && !err_pop)
                cnt <= cnt + 4'h1;
            else if (err_pop && !(err_push && cnt < 4'(ERRQ_DEPTH)))
                cnt <= cnt - 4'h1;
        end
    end

    // ------------------------------------------------------------
    // status registers: live views; the questionable bits show the latched ov_trip and oc_trip
    // ------------------------------------------------------------
    logic [15:0] next_oper, next_ques;
    always_comb
    begin
        next_oper          = 16'h0000;
        next_oper[OPB_ARM] = armed;
        next_oper[OPB_SS]  = st_s2[0];
        next_oper[OPB_LCK] = st_s2[1];
        next_oper[OPB_INT] = st_s2[2];
        next_oper[OPB_EXT] = st_s2[3];
        next_oper[OPB_WTG] = initiated;
        next_oper[OPB_SBY] = !o_output_on;
        next_oper[OPB_PWR] = st_s2[4];
        next_oper[OPB_CV]  = st_s2[5];
        next_oper[OPB_RS]  = st_s2[6];
        next_oper[OPB_CC]  = st_s2[7];
        next_oper[OPB_SOA] = !o_output_on || fault;
        next_ques          = 16'h0000;
        next_ques[QB_OV]   = ov_trip;
        next_ques[QB_OC]   = oc_trip;
    end

    // ------------------------------------------------------------
    // query answers, one cycle after the command
    // ------------------------------------------------------------
    logic [VAL_W-1:0] lim;
    assign lim = (i_cmd.qual == QUAL_MAX) ? LEVEL_MAX : LEVEL_MIN;

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_ans_valid <= 1'b0;
            o_ans       <= '0;
        end
        else
        begin
            o_ans_valid <= cmd_is && i_cmd.code >= Q_VOLT;
            o_ans.code  <= ERR_NONE;
            o_ans.value <= '0;
            if (cmd_is)
            begin
                unique case (i_cmd.code)
                    Q_VOLT:      o_ans.value <= (i_cmd.qual != QUAL_NONE) ? lim : volt_imm;
                    Q_VOLT_TRIG: o_ans.value <= (i_cmd.qual != QUAL_NONE) ? lim
                                             : (volt_pend ? volt_trg : volt_imm);
                    Q_VOLT_PROT: o_ans.value <= (i_cmd.qual != QUAL_NONE) ? lim : over_voltage_trip;
                    Q_CURR:      o_ans.value <= (i_cmd.qual != QUAL_NONE) ? lim : curr_imm;
                    Q_CURR_TRIG: o_ans.value <= (i_cmd.qual != QUAL_NONE) ? lim
                                             : (curr_pend ? curr_trg : curr_imm);
                    Q_CURR_PROT: o_ans.value <= (i_cmd.qual != QUAL_NONE) ? lim : over_current_trip;
                    Q_PER:       o_ans.value <= (i_cmd.qual == QUAL_MAX) ? VAL_W'(PER_MAX)
                                             : (i_cmd.qual == QUAL_MIN) ? VAL_W'(PER_MIN)
                                             : VAL_W'(step_now.step_dwell_period);
                    Q_MEAS_VOLT: o_ans.value <= mv_s2;
                    Q_MEAS_CURR: o_ans.value <= mc_s2;
                    Q_VERSION:
                    begin
                        o_ans.code  <= FW_REV;
                        o_ans.value <= HW_REV;
                    end
                    Q_ERROR:     o_ans.code  <= (cnt != '0) ? errq[rd_ptr] : ERR_NONE;
                    Q_OPER:      o_ans.value <= next_oper;
                    Q_QUES:      o_ans.value <= next_ques;
                    default:     ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs to the power stage
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_volt_set            <= LEVEL_MIN;
            o_curr_set            <= LEVEL_MIN;
            o_ovt_level           <= LEVEL_MAX;
            o_oct_level           <= LEVEL_MAX;
            o_operation_condition <= 16'h0000;
            o_questionable        <= 16'h0000;
        end
        else
        begin
            o_volt_set            <= volt_imm;
            o_curr_set            <= curr_imm;
            o_ovt_level           <= over_voltage_trip;
            o_oct_level           <= over_current_trip;
            o_operation_condition <= next_oper;
            o_questionable        <= next_ques;
        end
    end

endmodule : supply_setpoint_command_core

`default_nettype wire

// *** tb/supply_core_assertions.sv ***
// checker: port-level properties of the set-point command core
`timescale 1ns/1ps
`default_nettype none
module supply_core_checker
    import supply_cmd_pkg::*;
(
    input wire logic             i_mclk,
    input wire logic             i_reset,
    input wire logic             i_cmd_valid,
    input wire cmd_t             i_cmd,
    input wire logic [VAL_W-1:0] i_meas_volt,
    input wire logic [VAL_W-1:0] i_meas_curr,
    input wire logic             o_ans_valid,
    input wire answer_t          o_ans,
    input wire logic [VAL_W-1:0] o_volt_set,
    input wire logic [VAL_W-1:0] o_curr_set,
    input wire logic [VAL_W-1:0] o_ovt_level,
    input wire logic [VAL_W-1:0] o_oct_level,
    input wire logic             o_output_on,
    input wire logic [15:0]      o_operation_condition,
    input wire logic [15:0]      o_questionable
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    // short names for the taken command; set-point outputs lag the take by two edges, answers by one
    wire logic       cv  = i_cmd_valid;
    wire logic [4:0] c   = i_cmd.code;
    wire logic       clr = cv && c == CMD_PROT_CLR;
    a_volt_apply: assert property (cv && c == CMD_VOLT |->
        ##2 o_volt_set == $past(i_cmd.value, 2)) else $error("volt set not applied");
    a_query_answer: assert property (cv && c >= Q_VOLT |=> o_ans_valid)
        else $error("query unanswered");
    a_meas_answer: assert property (cv && c == Q_MEAS_VOLT && $stable(i_meas_volt) &&
        $past(i_meas_volt, 2) == i_meas_volt |=> o_ans.value == $past(i_meas_volt)) else $error("bad meas");
    a_ov_trip: assert property ((i_meas_volt > o_ovt_level)[*4] |-> ##[0:4]
        o_questionable[QB_OV] && !o_output_on) else $error("no over-voltage trip");
    a_oc_trip: assert property ((i_meas_curr > o_oct_level)[*4] |-> ##[0:4]
        o_questionable[QB_OC] && !o_output_on) else $error("no over-current trip");
    a_trip_held: assert property ($fell(o_questionable[QB_OV]) ||
        $fell(o_questionable[QB_OC]) |-> $past(clr, 2)) else $error("trip dropped");
    a_no_restart: assert property ($rose(o_output_on) |->
        o_questionable[1:0] == 2'b00) else $error("restart while tripped");
    a_trig_ignored: assert property (cv && c == CMD_TRIG && !o_operation_condition[OPB_WTG]
        && !$past(cv) ##1 !cv |=> $stable(o_volt_set) && $stable(o_curr_set)) else $error("trig taken");
endmodule : supply_core_checker
bind supply_setpoint_command_core supply_core_checker supply_core_checker_inst (.*);
`default_nettype wire

// *** tb/host_link_model.sv ***
// partner: host that issues one command and collects its answer
`timescale 1ns/1ps
`default_nettype none
module host_link_model
    import supply_cmd_pkg::*;
(
    input  wire logic    i_mclk,
    input  wire logic    i_ans_valid,
    input  wire answer_t i_ans,
    output var logic     o_cmd_valid,
    output var cmd_t     o_cmd
);
    initial o_cmd_valid = 1'b0;
    initial o_cmd = '0;
    // one-cycle request; lines inverted after release so stale data never looks valid
    task automatic issue(input cmd_code_t c, input qual_t q, input logic [VAL_W-1:0] v,
                         output logic got, output answer_t a);
        @(posedge i_mclk);
        o_cmd_valid <= 1'b1;
        o_cmd       <= '{c, q, v};
        @(posedge i_mclk);
        o_cmd_valid <= 1'b0;
        o_cmd       <= cmd_t'(~o_cmd);
        @(posedge i_mclk);
        got = i_ans_valid;
        a   = i_ans;
        #1;
    endtask : issue
endmodule : host_link_model
`default_nettype wire

// *** tb/supply_setpoint_command_core_bench.sv ***
// bench: scenario tasks for the set-point command core
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end
module supply_setpoint_command_core_bench;
    import supply_cmd_pkg::*;
    logic i_mclk = 1'b0, i_reset = 1'b1, i_cmd_valid, o_ans_valid, o_output_on, got;
    logic [15:0] i_meas_volt = '0, i_meas_curr = '0, o_volt_set, o_curr_set;
    logic [15:0] o_ovt_level, o_oct_level, o_operation_condition, o_questionable;
    logic [7:0]  i_status_pins = '0;
    cmd_t    i_cmd;
    answer_t o_ans, a;
    int      n_fail = 0, check_count = 0;
    always #5 i_mclk = ~i_mclk;
    supply_setpoint_command_core #(.DWELL_CYC(10)) supply_setpoint_command_core_inst (.*);
    host_link_model host_link_model_inst (.i_mclk(i_mclk), .i_ans_valid(o_ans_valid),
        .i_ans(o_ans), .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd));
    task automatic test_done;
        if (n_fail == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    task automatic q(input cmd_code_t c, input qual_t ql, input logic [15:0] v);
        host_link_model_inst.issue(c, ql, v, got, a);
    endtask : q
    task automatic w(input cmd_code_t c, input logic [15:0] v);
        q(c, QUAL_NONE, v);
    endtask : w
    task automatic wait_q(input int b);
        int t;
        t = 0;
        while (o_questionable[b] !== 1'b1 && t < 50) begin @(posedge i_mclk); #1; t++; end
        `CHK("trip", 1'b1, o_questionable[b])
        if (t == 50) test_done();
    endtask : wait_q
    task automatic t_levels;
        w(CMD_VOLT, 16'h1234);
        `CHK("volt_set", 16'h1234, o_volt_set)
        q(Q_VOLT_TRIG, QUAL_NONE, '0);
        `CHK("trig_dflt", 16'h1234, a.value)
        w(CMD_VOLT_TRIG, 16'h0555);
        w(CMD_CURR_TRIG, 16'h0777);
        w(CMD_VOLT, 16'h2222);
        w(CMD_TRIG, '0);
        `CHK("no_init", 16'h2222, o_volt_set)
        q(Q_VOLT_TRIG, QUAL_NONE, '0);
        `CHK("pending", 16'h0555, a.value)
        w(CMD_INIT, '0);
        w(CMD_TRIG, '0);
        `CHK("trig_v", 16'h0555, o_volt_set)
        `CHK("trig_c", 16'h0777, o_curr_set)
        w(CMD_VOLT_TRIG, 16'h0999);
        w(CMD_ABORT, '0);
        q(Q_VOLT_TRIG, QUAL_NONE, '0);
        `CHK("abort", 16'h0555, a.value)
    endtask : t_levels
    task automatic t_limits_errors;
        for (int k = 0; k < 6; k++) begin
            q(cmd_code_t'(Q_VOLT + k), QUAL_MAX, '0);
            `CHK("max", LEVEL_MAX, a.value)
            q(cmd_code_t'(Q_VOLT + k), QUAL_MIN, '0);
            `CHK("min", LEVEL_MIN, a.value)
        end
        w(CMD_PER, 16'h0005);
        w(CMD_PER, 16'h2710);
        q(Q_PER, QUAL_NONE, '0);
        `CHK("per", 16'h0005, a.value)
        q(Q_ERROR, QUAL_NONE, '0);
        `CHK("range", ERR_RANGE, a.code)
        q(Q_ERROR, QUAL_NONE, '0);
        `CHK("empty", ERR_NONE, a.code)
        repeat (9) w(CMD_PER, 16'hFFFF);
        for (int k = 0; k < 8; k++) begin
            q(Q_ERROR, QUAL_NONE, '0);
            `CHK("errq", (k == 7) ? ERR_OVERFLOW : ERR_RANGE, a.code)
        end
    endtask : t_limits_errors
    task automatic t_status;
        @(posedge i_mclk);
        i_meas_volt <= 16'h0ABC;
        i_meas_curr <= 16'h0123;
        i_status_pins <= 8'h81;
        repeat (4) @(posedge i_mclk);
        q(Q_MEAS_VOLT, QUAL_NONE, '0);
        `CHK("mvolt", 16'h0ABC, a.value)
        q(Q_MEAS_CURR, QUAL_NONE, '0);
        `CHK("mcurr", 16'h0123, a.value)
        q(Q_VERSION, QUAL_NONE, '0);
        `CHK("version", 32'h0100_0100, a)
        `CHK("ans_valid", 1'b1, got)
        q(Q_OPER, QUAL_NONE, '0);
        `CHK("oper", 16'h0C42, a.value)
        `CHK("oper_reg", 16'h0C42, o_operation_condition)
    endtask : t_status
    task automatic t_trip;
        @(posedge i_mclk);
        i_meas_volt <= '0;
        i_meas_curr <= '0;
        w(CMD_VOLT_PROT, 16'h0100);
        `CHK("ovt", 16'h0100, o_ovt_level)
        w(CMD_CURR_PROT, 16'h0100);
        `CHK("oct", 16'h0100, o_oct_level)
        w(CMD_START, '0);
        @(posedge i_mclk);
        i_meas_volt <= 16'h0200;
        wait_q(QB_OV);
        `CHK("ov_off", 1'b0, o_output_on)
        @(posedge i_mclk);
        i_meas_volt <= '0;
        w(CMD_START, '0);
        `CHK("refused", 1'b0, o_output_on)
        `CHK("latched", 1'b1, o_questionable[QB_OV])
        w(CMD_PROT_CLR, '0);
        `CHK("cleared", 16'h0000, o_questionable)
        w(CMD_START, '0);
        `CHK("restart", 1'b1, o_output_on)
        @(posedge i_mclk);
        i_meas_curr <= 16'h0200;
        wait_q(QB_OC);
        `CHK("oc_off", 1'b0, o_output_on)
    endtask : t_trip
    // step 0 dwells 5 units at 2222, step 1 has period 0 and stops the run
    task automatic t_seq;
        @(posedge i_mclk);
        i_meas_curr <= '0;
        w(CMD_CURR, 16'h0042);
        w(CMD_PROT_CLR, '0);
        w(CMD_MEM_SEL, 16'h0001);
        w(CMD_VOLT, 16'h0321);
        w(CMD_CURR, 16'h0042);
        w(CMD_VOLT_PROT, 16'h0100);
        w(CMD_CURR_PROT, 16'h0100);
        w(CMD_PER, '0);
        w(CMD_MEM_SEL, '0);
        w(CMD_ARM, 16'h0001);
        w(CMD_START, '0);
        repeat (40) @(posedge i_mclk);
        `CHK("step0", 16'h2222, o_volt_set)
        `CHK("dwell", 1'b1, o_output_on)
        repeat (20) @(posedge i_mclk);
        `CHK("step1", 16'h0321, o_volt_set)
        `CHK("per_zero", 1'b0, o_output_on)
    endtask : t_seq
    initial begin #500us; n_fail++; test_done(); end
    initial begin
        repeat (5) @(posedge i_mclk);
        i_reset <= 1'b0;
        t_levels();
        t_limits_errors();
        t_status();
        t_trip();
        t_seq();
        test_done();
    end
endmodule : supply_setpoint_command_core_bench
`default_nettype wire
